// File: core/scp_host.sv
// Host controller for the serial configuration port: cycles and strap mode
`timescale 1ns/1ns
module scp_host
   import scp_pkg::*;
#(
   parameter int HALF_CYC = 2,
   parameter int STRAP_WAIT_CYC = SCP_STRAP_CYC
)
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire logic cmd_read,
   input wire logic [1:0] cmd_count,
   input wire logic [4:0] cmd_addr,
   input wire logic [31:0] cmd_wdata,
   output logic rsp_valid,
   output logic [31:0] rsp_rdata,
   output logic cfg_warn,
   output logic bit_order_select,
   input wire logic strap_mode,
   input wire logic clock_mode_strap,
   input wire logic format_strap,
   input wire logic power_down_strap,
   output logic strap_ready,
   input wire logic pulse_reset,
   output logic reset_or_strap_pin,
   output logic sclk,
   output logic cs_n,
   output logic sdio_out,
   output logic sdio_oe,
   input wire logic sdio_in
);
   typedef enum logic [5:0] {
      ST_IDLE = 6'b000001,
      ST_RSTP = 6'b000010,
      ST_INSTR = 6'b000100,
      ST_DATA = 6'b001000,
      ST_DONE = 6'b010000,
      ST_STRAP = 6'b100000
   } scp_state_t;

   typedef struct packed {
      scp_state_t st;
      logic cs_n;
      logic rstpin;
      logic [SCP_CNT_W-1:0] cnt;
      logic [15:0] settle;
      logic read;
      logic [1:0] left;
      logic [1:0] idx;
      logic [4:0] addr;
      logic [31:0] wdata;
      logic [31:0] rdata;
      logic lsb;
      logic rsp;
      logic warn;
      logic go;
      logic [7:0] tx;
      logic fmt_last;
   } scp_host_t;

   scp_host_t q;
   scp_host_t next_q;
   logic eng_done;
   logic [7:0] eng_rx;
   logic eng_sclk;
   logic eng_out;
   logic eng_oe;
   logic [7:0] cfg_byte;

   // Next device address for a byte; stops at the range ends
   function automatic logic [4:0] scp_step(input logic [4:0] a, input logic lsb);
      logic [4:0] r;
      r = a;
      if (lsb)
      begin
         if (a != SCP_ADDR_HIGH)
            r = a + 5'h01;
      end
      else if (a != SCP_ADDR_LOW)
         r = a - 5'h01;
      return r;
   endfunction

   function automatic logic [7:0] scp_pick(input logic [31:0] w, input logic [1:0] i);
      return w[i*8 +: 8];
   endfunction

   scp_bit_engine #(
      .HALF(HALF_CYC)
   ) u_eng (
      .mclk(mclk),
      .rst_n(rst_n),
      .start(q.go),
      .drive(q.st == ST_INSTR || !q.read),
      .lsb_first(q.lsb),
      .tx_byte(q.tx),
      .sdio_in(sdio_in),
      .done(eng_done),
      .rx_byte(eng_rx),
      .sclk(eng_sclk),
      .sdio_out(eng_out),
      .sdio_oe(eng_oe)
   );

   always_comb
   begin
      cfg_byte = scp_pick(q.wdata, q.idx);
      next_q = q;
      next_q.go = 1'b0;
      next_q.rsp = 1'b0;
      case (q.st)
         ST_IDLE:
         begin
            next_q.cs_n = 1'b1;
            if (pulse_reset)
            begin
               next_q.st = ST_RSTP;
               next_q.rstpin = 1'b1;
               next_q.cnt = '0;
            end
            else if (strap_mode)
            begin
               next_q.st = ST_STRAP;
               next_q.rstpin = 1'b1;
               next_q.cs_n = power_down_strap;
               next_q.settle = '0;
               next_q.fmt_last = format_strap;
            end
            else if (cmd_valid)
            begin
               next_q.read = cmd_read;
               next_q.left = cmd_count;
               next_q.addr = cmd_addr;
               next_q.wdata = cmd_wdata;
               next_q.rdata = '0;
               next_q.idx = 2'h0;
               next_q.warn = 1'b0;
               // Instruction byte: direction, count, start address
               next_q.tx = {cmd_read, cmd_count, cmd_addr};
               next_q.cs_n = 1'b0;
               next_q.go = 1'b1;
               next_q.st = ST_INSTR;
            end
         end
         ST_RSTP:
         begin
            // Pulse high then low; device returns to instruction phase
            next_q.cs_n = 1'b1;
            if (q.cnt == SCP_CNT_W'(SCP_RESET_CYC - 1))
            begin
               next_q.rstpin = 1'b0;
               next_q.lsb = 1'b0;
               next_q.st = ST_IDLE;
            end
            else
               next_q.cnt = q.cnt + SCP_CNT_W'(1);
         end
         ST_INSTR, ST_DATA:
         begin
            if (eng_done)
            begin
               if (q.st == ST_DATA)
               begin
                  if (q.read)
                     next_q.rdata[q.idx*8 +: 8] = eng_rx;
                  // Bit order follows a config write at once
                  else if (q.addr == SCP_REG_PORT_CONFIGURATION)
                  begin
                     next_q.lsb = cfg_byte[SCP_CFG_ORDER_BIT];
                     if (q.left != 2'h0 && next_q.lsb != q.lsb)
                        next_q.warn = 1'b1;
                  end
                  // Device steps its address in the order just written
                  next_q.addr = scp_step(q.addr, next_q.lsb);
               end
               if (q.st == ST_DATA && q.left == 2'h0)
                  next_q.st = ST_DONE;
               else
               begin
                  if (q.st == ST_DATA)
                  begin
                     next_q.left = q.left - 2'h1;
                     next_q.idx = q.idx + 2'h1;
                  end
                  next_q.tx = scp_pick(q.wdata, next_q.idx);
                  next_q.go = 1'b1;
                  next_q.st = ST_DATA;
               end
            end
         end
         ST_DONE:
         begin
            // Select held to the last bit, then raised
            next_q.cs_n = 1'b1;
            next_q.rsp = 1'b1;
            next_q.st = ST_IDLE;
         end
         ST_STRAP:
         begin
            // Straps driven live on sclk and sdio; select follows power_down_strap one cycle later
            next_q.cs_n = power_down_strap;
            if (format_strap != q.fmt_last)
               next_q.settle = '0;
            else if (q.settle != 16'(STRAP_WAIT_CYC))
               next_q.settle = q.settle + 16'h0001;
            next_q.fmt_last = format_strap;
            if (!strap_mode)
            begin
               next_q.st = ST_RSTP;
               next_q.cnt = '0;
            end
         end
         default:
            next_q.st = ST_IDLE;
      endcase
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         q <= '0;
         q.st <= ST_IDLE;
         q.cs_n <= 1'b1;
      end
      else
         q <= next_q;
   end

   assign cmd_ready = (q.st == ST_IDLE) && !pulse_reset && !strap_mode;
   assign rsp_valid = q.rsp;
   assign rsp_rdata = q.rdata;
   assign cfg_warn = q.warn;
   assign bit_order_select = q.lsb;
   assign reset_or_strap_pin = q.rstpin;
   assign cs_n = q.cs_n;
   assign strap_ready = (q.st == ST_STRAP) && (q.settle == 16'(STRAP_WAIT_CYC));
   assign sclk = (q.st == ST_STRAP) ? clock_mode_strap : eng_sclk;
   assign sdio_out = (q.st == ST_STRAP) ? format_strap : eng_out;
   assign sdio_oe = (q.st == ST_STRAP) ? 1'b1 : eng_oe;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   AST_CS_LOW_WHILE_CLOCKING: assert property (@(posedge mclk) disable iff (!rst_n)
      (q.st == ST_INSTR || q.st == ST_DATA) |-> !cs_n)
      else $error("select high during cycle");
   AST_NO_DRIVE_READ_DATA: assert property (@(posedge mclk) disable iff (!rst_n)
      (q.st == ST_DATA && q.read) |-> !sdio_oe)
      else $error("host drives line in read phase");
   AST_INSTR_FIELDS: assert property (@(posedge mclk) disable iff (!rst_n)
      (q.st == ST_IDLE && cmd_valid && cmd_ready)
      |=> (q.tx == {$past(cmd_read), $past(cmd_count), $past(cmd_addr)}))
      else $error("instruction byte mismatch");
   AST_RESP_AFTER_DONE: assert property (@(posedge mclk) disable iff (!rst_n)
      (q.st == ST_DONE) |=> (rsp_valid && cs_n))
      else $error("no response after cycle");
   AST_RESET_PULSE: assert property (@(posedge mclk) disable iff (!rst_n)
      (q.st == ST_RSTP && q.cnt == '0) |-> reset_or_strap_pin)
      else $error("reset pin not high in pulse");
   AST_STRAP_PINS: assert property (@(posedge mclk) disable iff (!rst_n)
      (q.st == ST_STRAP) |-> (cs_n == $past(power_down_strap) && sdio_oe))
      else $error("strap pins not followed");
   AST_ORDER_RESET: assert property (@(posedge mclk) disable iff (!rst_n)
      (q.st == ST_RSTP && q.cnt == SCP_CNT_W'(SCP_RESET_CYC - 1)) |=> !bit_order_select)
      else $error("bit order not default");
   AST_ADDR_CLAMP: assert property (@(posedge mclk) disable iff (!rst_n)
      (q.st == ST_DATA && eng_done && q.lsb && q.addr == SCP_ADDR_HIGH)
      |=> (q.addr == SCP_ADDR_HIGH))
      else $error("address wrapped");
   CVR_WRITE: cover property (@(posedge mclk) rsp_valid && !q.read);
   CVR_READ4: cover property (@(posedge mclk) rsp_valid && q.read && q.idx == 2'h3);
   CVR_STRAP: cover property (@(posedge mclk) strap_ready);
   CVR_WARN: cover property (@(posedge mclk) rsp_valid && cfg_warn);
endmodule

// File: core/scp_pkg.sv
// Package: constants for the serial configuration port host controller
package scp_pkg;
   localparam int SCP_ADDR_W = 5;
   localparam int SCP_BYTE_W = 8;
   localparam int SCP_MAX_BYTES = 4;
   localparam int SCP_BIT_RW = 7;
   localparam int SCP_BIT_CNT_HI = 6;
   localparam int SCP_BIT_CNT_LO = 5;
   localparam logic [4:0] SCP_ADDR_LOW = 5'h00;
   localparam logic [4:0] SCP_ADDR_HIGH = 5'h1F;
   localparam int SCP_CFG_ORDER_BIT = 6;
   localparam int SCP_CFG_SRST_BIT = 5;
   localparam int SCP_CFG_LONG_BIT = 4;
   // Register offsets and reset values of the device
   localparam logic [4:0] SCP_REG_PORT_CONFIGURATION = 5'h00;
   localparam logic [4:0] SCP_REG_POWER_DOWN_CONTROL = 5'h01;
   localparam logic [4:0] SCP_REG_INPUT_DATA_CONTROL = 5'h02;
   localparam logic [4:0] SCP_REG_IN_PHASE_GAIN_TRIM = 5'h03;
   localparam logic [4:0] SCP_REG_IN_PHASE_SCALE_RESISTOR = 5'h04;
   localparam logic [4:0] SCP_REG_IN_PHASE_COMMON_MODE_RESISTOR = 5'h05;
   localparam logic [4:0] SCP_REG_QUADRATURE_GAIN_TRIM = 5'h06;
   localparam logic [4:0] SCP_REG_QUADRATURE_SCALE_RESISTOR = 5'h07;
   localparam logic [4:0] SCP_REG_QUADRATURE_COMMON_MODE_RESISTOR = 5'h08;
   localparam logic [4:0] SCP_REG_IN_PHASE_AUX_LEVEL_LOW = 5'h09;
   localparam logic [4:0] SCP_REG_IN_PHASE_AUX_CONTROL = 5'h0A;
   localparam logic [4:0] SCP_REG_QUADRATURE_AUX_LEVEL_LOW = 5'h0B;
   localparam logic [4:0] SCP_REG_QUADRATURE_AUX_CONTROL = 5'h0C;
   localparam logic [4:0] SCP_REG_REFERENCE_RESISTOR_TRIM = 5'h0D;
   localparam logic [4:0] SCP_REG_CALIBRATION_CONTROL = 5'h0E;
   localparam logic [4:0] SCP_REG_CALIBRATION_MEMORY_STATUS = 5'h0F;
   localparam logic [4:0] SCP_REG_TRIM_MEMORY_POINTER = 5'h10;
   localparam logic [4:0] SCP_REG_TRIM_MEMORY_VALUE = 5'h11;
   localparam logic [4:0] SCP_REG_TRIM_MEMORY_ACCESS = 5'h12;
   localparam logic [4:0] SCP_REG_SAMPLE_CLOCK_RETIMING = 5'h14;
   localparam logic [4:0] SCP_REG_REVISION_ID = 5'h1F;
   localparam logic [7:0] SCP_RST_PORT_CONFIGURATION = 8'h00;
   localparam logic [7:0] SCP_RST_POWER_DOWN_CONTROL = 8'h40;
   localparam logic [7:0] SCP_RST_INPUT_DATA_CONTROL = 8'h34;
   localparam logic [7:0] SCP_RST_TRIM_MEMORY_VALUE = 8'h3F;
   // Timing
   localparam int SCP_CLK_HZ = 25000000;
   localparam int SCP_SCLK_MAX_HZ = 25000000;
   // Serial clock half period in mclk cycles (25 MHz limit gives at least 1)
   localparam int SCP_HALF_MIN = (SCP_CLK_HZ + 2 * SCP_SCLK_MAX_HZ - 1) / (2 * SCP_SCLK_MAX_HZ);
   localparam int SCP_RESET_PULSE_NS = 50;
   localparam int SCP_RESET_CYC = (SCP_RESET_PULSE_NS * (SCP_CLK_HZ / 1000000) + 999) / 1000;
   localparam int SCP_STRAP_SETTLE_NS = 1000;
   localparam int SCP_STRAP_CYC = (SCP_STRAP_SETTLE_NS * (SCP_CLK_HZ / 1000000) + 999) / 1000;
   localparam int SCP_CNT_W = 8;
endpackage

// File: core/scp_bit_engine.sv
// Bit engine: drives serial clock edges and shifts one byte out or in
`timescale 1ns/1ns
module scp_bit_engine
   import scp_pkg::*;
#(
   parameter int HALF = 2
)
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic start,
   input wire logic drive,
   input wire logic lsb_first,
   input wire logic [7:0] tx_byte,
   input wire logic sdio_in,
   output logic done,
   output logic [7:0] rx_byte,
   output logic sclk,
   output logic sdio_out,
   output logic sdio_oe
);
   typedef struct packed {
      logic busy;
      logic sclk;
      logic [3:0] bit_n;
      logic [SCP_CNT_W-1:0] tick;
      logic [7:0] sh;
      logic [7:0] rx;
      logic done;
      logic drive;
      logic lsb;
      logic [1:0] in_sync;
   } scp_eng_t;

   scp_eng_t q;
   scp_eng_t next_q;
   logic in_bit;

   always_comb
   begin
      next_q = q;
      next_q.done = 1'b0;
      next_q.in_sync = {q.in_sync[0], sdio_in};
      in_bit = q.in_sync[1];
      if (start && !q.busy)
      begin
         next_q.busy = 1'b1;
         next_q.sh = tx_byte;
         next_q.drive = drive;
         next_q.lsb = lsb_first;
         next_q.bit_n = 4'h0;
         next_q.tick = '0;
      end
      else if (q.busy)
      begin
         if (q.tick == SCP_CNT_W'(HALF - 1))
         begin
            next_q.tick = '0;
            if (!q.sclk)
            begin
               // Rising edge: device samples here
               next_q.sclk = 1'b1;
               if (!q.drive)
               begin
                  // Device moved the line on the prior falling edge
                  if (q.lsb)
                     next_q.rx = {in_bit, q.rx[7:1]};
                  else
                     next_q.rx = {q.rx[6:0], in_bit};
               end
            end
            else
            begin
               next_q.sclk = 1'b0;
               if (q.bit_n == 4'h7)
               begin
                  next_q.busy = 1'b0;
                  next_q.done = 1'b1;
               end
               else
               begin
                  next_q.bit_n = q.bit_n + 4'h1;
                  next_q.sh = q.lsb ? {1'b0, q.sh[7:1]} : {q.sh[6:0], 1'b0};
               end
            end
         end
         else
            next_q.tick = q.tick + SCP_CNT_W'(1);
      end
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         q <= '0;
      else
         q <= next_q;
   end

   assign done = q.done;
   assign rx_byte = q.rx;
   assign sclk = q.sclk;
   // Bit presented half a period ahead of the rising edge
   assign sdio_out = q.lsb ? q.sh[0] : q.sh[7];
   assign sdio_oe = q.busy & q.drive;

   AST_ENG_OE_ONLY_WRITE: assert property (@(posedge mclk) disable iff (!rst_n)
      sdio_oe |-> q.drive)
      else $error("data line driven during read");
   AST_ENG_STABLE_AT_RISE: assert property (@(posedge mclk) disable iff (!rst_n)
      (sdio_oe && $rose(sclk)) |-> $stable(sdio_out))
      else $error("data changed at rising edge");
endmodule

// File: verif/scp_dev_model.sv
// Device model: register file behind the serial configuration port
`timescale 1ns/1ns
module scp_dev_model
   import scp_pkg::*;
#(
   parameter logic [7:0] REV_ID = 8'h5C // Arbitrary value
)
(
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic sdio,
   input wire logic rst_pin,
   output logic dev_out,
   output logic dev_oe
);
   logic [7:0] regs [0:31];
   logic [7:0] instr;
   logic [7:0] sh;
   logic [4:0] addr;
   int n = 0;
   function automatic logic [7:0] wmask(input logic [4:0] a);
      case (a)
         5'h00: return 8'h70;
         5'h01, 5'h02, 5'h04, 5'h05, 5'h07, 5'h08: return 8'hBF;
         5'h03, 5'h06, 5'h0D, 5'h10, 5'h11: return 8'h3F;
         5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h0E, 5'h0F, 5'h12, 5'h14: return 8'hFF;
         default: return 8'h00;
      endcase
   endfunction
   task automatic load_defaults(input logic keep_cfg);
      logic [7:0] c;
      c = regs[0];
      foreach (regs[i]) regs[i] = 8'h00;
      regs[1] = SCP_RST_POWER_DOWN_CONTROL;
      regs[2] = SCP_RST_INPUT_DATA_CONTROL;
      regs[17] = SCP_RST_TRIM_MEMORY_VALUE;
      regs[31] = REV_ID;
      if (keep_cfg)
         regs[0] = c;
   endtask
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      if (a != 5'h00 && regs[0][5])
         return;
      regs[a] = (regs[a] & ~wmask(a)) | (d & wmask(a));
      if (a == 5'h00 && d[5])
         load_defaults(1'b1);
   endtask
   initial
   begin
      dev_out = 1'b0;
      dev_oe = 1'b0;
      load_defaults(1'b0);
   end
   // Select high or reset pin: release line, restart instruction phase
   always @(posedge cs_n or posedge rst_pin)
   begin
      n = 0;
      dev_oe = 1'b0;
      dev_out = ~dev_out;
      if (rst_pin)
         load_defaults(1'b0);
   end
   always @(posedge sclk)
   begin
      if (!cs_n && !rst_pin)
      begin
         if (n < 8)
         begin
            instr = regs[0][6] ? {sdio, instr[7:1]} : {instr[6:0], sdio};
            addr = instr[4:0];
         end
         else
         begin
            if (!instr[7])
               sh = regs[0][6] ? {sdio, sh[7:1]} : {sh[6:0], sdio};
            if ((n - 8) % 8 == 7)
            begin
               if (!instr[7] && (n - 8) / 8 <= int'(instr[6:5]))
                  wr(addr, sh);
               if (regs[0][6])
                  addr = (addr == SCP_ADDR_HIGH) ? addr : addr + 5'h01;
               else
                  addr = (addr == SCP_ADDR_LOW) ? addr : addr - 5'h01;
            end
         end
         n++;
      end
   end
   always @(negedge sclk)
   begin
      if (!cs_n && !rst_pin && instr[7] && n >= 8)
      begin
         if ((n - 8) % 8 == 0)
            sh = regs[addr];
         dev_oe = 1'b1;
         dev_out = regs[0][6] ? sh[(n - 8) % 8] : sh[7 - (n - 8) % 8];
      end
   end
endmodule

// File: verif/scp_host_bench.sv
// Testbench: host controller against the behavioural device model
`timescale 1ns/1ns
module scp_host_bench;
   import scp_pkg::*;
   localparam logic [7:0] REV = 8'h5C; // Arbitrary value
   logic mclk = 0, rst_n = 0, cmd_valid = 0, cmd_read = 0, strap_mode = 0, pulse_reset = 0;
   logic clock_mode_strap = 0, format_strap = 0, power_down_strap = 0;
   logic [1:0] cmd_count = 0;
   logic [4:0] cmd_addr = 0;
   logic [31:0] cmd_wdata = 0;
   logic [31:0] rsp_rdata;
   logic cmd_ready, rsp_valid, cfg_warn, bit_order_select, strap_ready, reset_or_strap_pin;
   logic sclk, cs_n, sdio_out, sdio_oe, sdio_in, dev_out, dev_oe, first_bit, lsb = 0;
   int failures = 0, compares = 0, edges = 0, clash = 0;
   realtime last_rise = -1000.0;
   assign sdio_in = sdio_oe ? sdio_out : dev_out;
   always #20 mclk = ~mclk;
   scp_host #(.HALF_CYC(4), .STRAP_WAIT_CYC(4)) u_scp_host (.mclk(mclk), .rst_n(rst_n),
      .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_read(cmd_read), .cmd_count(cmd_count),
      .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
      .cfg_warn(cfg_warn), .bit_order_select(bit_order_select), .strap_mode(strap_mode),
      .clock_mode_strap(clock_mode_strap), .format_strap(format_strap),
      .power_down_strap(power_down_strap), .strap_ready(strap_ready),
      .pulse_reset(pulse_reset), .reset_or_strap_pin(reset_or_strap_pin), .sclk(sclk),
      .cs_n(cs_n), .sdio_out(sdio_out), .sdio_oe(sdio_oe), .sdio_in(sdio_in));
   scp_dev_model #(.REV_ID(REV)) u_scp_dev_model (.sclk(sclk), .cs_n(cs_n), .sdio(sdio_out),
      .rst_pin(reset_or_strap_pin), .dev_out(dev_out), .dev_oe(dev_oe));
   // ------------------------------
   // Wire monitors
   // ------------------------------
   always @(posedge sclk)
   begin
      if (!cs_n && !reset_or_strap_pin)
      begin
         if (edges == 0)
            first_bit = sdio_out;
         edges++;
         if ($realtime - last_rise < 40.0)
            clash++;
         last_rise = $realtime;
      end
   end
   always @(negedge mclk)
      if ((sdio_oe && dev_oe) || (cs_n && !reset_or_strap_pin && (sdio_oe || dev_oe)))
         clash++;
   // ------------------------------
   // Shared tasks
   // ------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         failures++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict;
      $display("failures %0d compares %0d", failures, compares);
      if (failures == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic xfer(input logic rd, input logic [1:0] cnt, input logic [4:0] a,
      input logic [31:0] wd);
      @(negedge mclk);
      repeat (100) if (cmd_ready !== 1'b1) @(negedge mclk);
      edges = 0;
      cmd_read = rd;
      cmd_count = cnt;
      cmd_addr = a;
      cmd_wdata = wd;
      cmd_valid = 1'b1;
      @(negedge mclk);
      cmd_valid = 1'b0;
      repeat (3000) if (rsp_valid !== 1'b1) @(negedge mclk);
      check(32'(rsp_valid), 32'h1);
      check(32'(edges), 32'(8 * (int'(cnt) + 2)));
      check(32'(first_bit), 32'(lsb ? a[0] : rd));
   endtask
   task automatic rd1(input logic [4:0] a, input logic [7:0] exp);
      xfer(1'b1, 2'd0, a, 32'h0);
      check(rsp_rdata, {24'h0, exp});
   endtask
   // ------------------------------
   // Scenarios
   // ------------------------------
   task automatic t_reset;
      int hi;
      xfer(1'b0, 2'd0, 5'h03, 32'h2A);
      xfer(1'b0, 2'd0, 5'h00, 32'h40);
      @(negedge mclk);
      pulse_reset = 1'b1;
      @(negedge mclk);
      pulse_reset = 1'b0;
      hi = int'(reset_or_strap_pin);
      repeat (20) @(negedge mclk) hi += int'(reset_or_strap_pin);
      check(32'(hi), 32'(SCP_RESET_CYC));
      check(32'(bit_order_select), 32'h0);
      rd1(5'h03, 8'h00);
   endtask
   task automatic t_defaults;
      logic [4:0] da [7] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h11, 5'h13, 5'h1F};
      logic [7:0] dv [7] = '{8'h00, 8'h40, 8'h34, 8'h00, 8'h3F, 8'h00, REV};
      foreach (da[i]) rd1(da[i], dv[i]);
      xfer(1'b0, 2'd0, 5'h03, 32'hFF);
      rd1(5'h03, 8'h3F);
      xfer(1'b0, 2'd0, 5'h15, 32'hFF);
      rd1(5'h15, 8'h00);
   endtask
   task automatic t_msb;
      xfer(1'b0, 2'd3, 5'h0C, 32'h44332211);
      check(32'(u_scp_dev_model.regs[9]), 32'h44);
      xfer(1'b1, 2'd3, 5'h0C, 32'h0);
      check(rsp_rdata, 32'h44332211);
      for (int c = 0; c < 4; c++)
      begin
         xfer(1'b1, 2'(c), 5'h02, 32'h0);
         check(rsp_rdata, (c == 0) ? 32'h34 : 32'h4034);
      end
   endtask
   task automatic t_lsb;
      xfer(1'b0, 2'd1, 5'h01, 32'h4040);
      lsb = 1'b1;
      check(32'(bit_order_select), 32'h1);
      xfer(1'b0, 2'd2, 5'h0B, 32'h003C5AA5);
      xfer(1'b1, 2'd2, 5'h0B, 32'h0);
      check(rsp_rdata, 32'h003C5AA5);
      xfer(1'b1, 2'd3, 5'h1D, 32'h0);
      check(rsp_rdata, {REV, REV, 16'h0});
      xfer(1'b0, 2'd0, 5'h00, 32'h0);
      lsb = 1'b0;
      check({30'h0, cfg_warn, bit_order_select}, 32'h0);
      xfer(1'b0, 2'd1, 5'h00, 32'h0140);
      check({30'h0, cfg_warn, bit_order_select}, 32'h3);
      check(32'(u_scp_dev_model.regs[1]), 32'h41);
      lsb = 1'b1;
      xfer(1'b0, 2'd0, 5'h00, 32'h0);
      lsb = 1'b0;
      check(32'(bit_order_select), 32'h0);
   endtask
   task automatic t_srst;
      xfer(1'b0, 2'd0, 5'h03, 32'h15);
      xfer(1'b0, 2'd0, 5'h00, 32'h20);
      xfer(1'b0, 2'd0, 5'h04, 32'h11);
      rd1(5'h00, 8'h20);
      xfer(1'b0, 2'd0, 5'h00, 32'h0);
      rd1(5'h03, 8'h00);
      rd1(5'h04, 8'h00);
   endtask
   task automatic t_strap;
      xfer(1'b0, 2'd0, 5'h02, 32'h0);
      @(negedge mclk);
      clock_mode_strap = 1'b1;
      power_down_strap = 1'b1;
      strap_mode = 1'b1;
      repeat (3) @(negedge mclk);
      check({28'h0, sclk, cs_n, sdio_out, sdio_oe}, 32'hD);
      check({30'h0, cmd_ready, reset_or_strap_pin}, 32'h1);
      repeat (8) @(negedge mclk);
      check(32'(strap_ready), 32'h1);
      format_strap = 1'b1;
      repeat (2) @(negedge mclk);
      check({30'h0, strap_ready, sdio_out}, 32'h1);
      repeat (8) @(negedge mclk);
      check(32'(strap_ready), 32'h1);
      clock_mode_strap = 1'b0;
      power_down_strap = 1'b0;
      repeat (2) @(negedge mclk);
      check({30'h0, sclk, cs_n}, 32'h0);
      power_down_strap = 1'b1;
      @(negedge mclk);
      strap_mode = 1'b0;
      repeat (20) @(negedge mclk);
      rd1(5'h02, 8'h34);
   endtask
   initial
   begin
      repeat (4) @(negedge mclk);
      rst_n = 1'b1;
      t_reset;
      t_defaults;
      t_msb;
      t_lsb;
      t_srst;
      t_strap;
      check(32'(clash), 32'h0);
      give_verdict;
   end
   initial
   begin
      #1000000;
      failures++;
      give_verdict;
   end
endmodule
